/* File: rst_seq_pkg.sv */
// Package with register map, field positions, reset values and timing counts.
package rst_seq_pkg;
   // Register indices on the plain register port.
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_IDENT = 4'h2;
   localparam logic [3:0] REG_STRAPS = 4'h3;
   localparam logic [3:0] REG_CHAN_STAT = 4'h4;
   // Control register fields.
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_BLK_MASTER_BIT = 1;
   localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
   // Channel status register fields: category code and generation bit.
   localparam int CS_CAT_LSB = 0;
   localparam int CS_CAT_W = 7;
   localparam int CS_GEN_BIT = 7;
   localparam logic [7:0] CS_RESET_VAL = 8'h00;
   // Identity fields; the values are arbitrary.
   localparam logic [3:0] ID_CODE = 4'hA;
   localparam logic [3:0] REV_CODE = 4'h1;
   // Settle time of the clock recovery loop.
   localparam int PLL_SETTLE_US = 100;
   localparam int CLK_MHZ = 20;
   localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
   localparam int SETTLE_W = 12;
   // Least length of an external block-start pulse, in master clocks.
   localparam int BLK_IN_MIN = 3;
   // Subframes per channel status block (two per frame, 192 frames).
   localparam int SUBFRAMES_PER_BLOCK = 384;
   localparam int SUBF_W = 9;
   typedef enum logic [1:0] {ST_LOWPWR, ST_SETTLE, ST_RUN} seq_state_t;
endpackage

/* File: strap_latch.sv */
// Strap sampling register for mode pins at reset exit.
`timescale 1ns/10ps
module strap_latch (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_pins,
   output logic o_sampled,
   output logic [2:0] o_straps
);
   logic taken_q;
   logic [2:0] straps_q;

   // The first clock after release captures the pins; later drive by the
   // device itself can never reach the latch until reset comes back.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         taken_q <= 1'b0;
         straps_q <= 3'h0;
      end else if (!taken_q) begin
         taken_q <= 1'b1;
         straps_q <= i_pins;
      end
   end

   assign o_sampled = taken_q;
   assign o_straps = straps_q;
endmodule

/* File: block_start.sv */
// Block-start generation and detection for transmitter alignment.
`timescale 1ns/10ps
module block_start (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_master,
   input wire logic i_subframe,
   input wire logic i_sync_in,
   output logic o_sync_out,
   output logic o_block_first
);
   logic [rst_seq_pkg::SUBF_W-1:0] subf_q;
   logic [1:0] high_q;
   logic armed_q;
   logic out_q;
   wire last_subf;
   wire ext_start;
   wire new_block;

   assign last_subf = subf_q ==
      rst_seq_pkg::SUBF_W'(rst_seq_pkg::SUBFRAMES_PER_BLOCK - 1);
   // A long enough high level arms a restart at the next subframe.
   assign ext_start = !i_master && armed_q;
   assign new_block = i_subframe && (ext_start || last_subf);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !i_enable) begin
         subf_q <= '0;
         high_q <= 2'h0;
         armed_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         if (!i_sync_in || i_master) begin
            high_q <= 2'h0;
         end else if (high_q != 2'(rst_seq_pkg::BLK_IN_MIN - 1)) begin
            high_q <= high_q + 2'h1;
         end else begin
            armed_q <= 1'b1;
         end
         if (new_block) begin
            subf_q <= '0;
            armed_q <= 1'b0;
            out_q <= 1'b1;
         end else if (i_subframe) begin
            subf_q <= subf_q + 1'b1;
            out_q <= 1'b0;
         end
      end
   end

   assign o_sync_out = out_q;
   assign o_block_first = new_block;
endmodule

/* File: reset_startup_mode_control.sv */
// Reset, power-down, start-up sequencing and static mode selection.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module reset_startup_mode_control (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_control_mode,
   input wire logic i_input_port_master_select,
   input wire logic i_pll_locked,
   input wire logic i_subframe,
   input wire logic i_line_data,
   input wire logic i_audio_data,
   input wire logic i_emphasis_pin,
   input wire logic i_original_indicator,
   input wire logic i_copy_pin,
   input wire logic i_emphasis_value,
   input wire logic i_block_start_sync,
   output logic o_emphasis_pin,
   output logic o_emphasis_pin_oe_n,
   output logic o_original_indicator,
   output logic o_original_indicator_oe_n,
   output logic o_copy_pin,
   output logic o_copy_pin_oe_n,
   output logic o_block_start_sync,
   output logic o_block_start_sync_oe_n,
   output logic o_block_first,
   output logic o_line_out_pos,
   output logic o_line_out_neg,
   output logic o_audio_out,
   output logic o_core_active,
   output logic o_input_port_master,
   output logic o_software_mode,
   output logic o_addr_bit
);
   //////////////////////////////////////////////////////////////////////////
   rst_seq_pkg::seq_state_t state_q;
   rst_seq_pkg::seq_state_t state_d;
   logic [7:0] ctrl_q;
   logic [7:0] chan_stat_q;
   logic [7:0] rdata_q;
   logic [rst_seq_pkg::SETTLE_W-1:0] settle_q;
   logic run_q;
   logic outs_on_q;
   logic line_pos_q;
   logic line_neg_q;
   logic audio_q;
   logic original_indicator_q;
   logic emphasis_pin_q;
   logic copy_q;
   logic blk_q;
   logic blk_oe_n_q;
   logic blk_first_q;
   logic ipm_q;
   logic sw_q;
   logic addr_bit_q;
   logic strap_oe_n_q;
   wire sampled;
   wire [2:0] straps;
   wire blk_sync_out;
   wire blk_first;
   wire wr_ctrl;
   wire wr_chan;
   wire run_write;
   wire settled;
   wire is_original;
   wire blk_master;
   wire [7:0] rd_mux;
   wire run_d;
   wire outs_on_d;
   wire line_pos_d;
   wire line_neg_d;
   wire audio_d;
   wire original_indicator_d;
   wire emphasis_pin_d;
   wire copy_d;
   wire blk_d;
   wire addr_bit_d;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = a == r;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Register port decode.
   assign wr_ctrl = i_wr && hit(i_addr, rst_seq_pkg::REG_CONTROL);
   assign wr_chan = i_wr && hit(i_addr, rst_seq_pkg::REG_CHAN_STAT);
   assign run_write = wr_ctrl && i_wdata[rst_seq_pkg::CTRL_RUN_BIT];
   assign blk_master = ctrl_q[rst_seq_pkg::CTRL_BLK_MASTER_BIT];
   assign settled = settle_q ==
      rst_seq_pkg::SETTLE_W'(rst_seq_pkg::PLL_SETTLE_CYC - 1);

   // Category codes with bit 0 set invert the meaning of the generation bit,
   // so the generation bit alone cannot say whether the source is a copy.
   assign is_original = chan_stat_q[rst_seq_pkg::CS_CAT_LSB] ^
      chan_stat_q[rst_seq_pkg::CS_GEN_BIT];

   assign rd_mux =
      hit(i_addr, rst_seq_pkg::REG_CONTROL) ? ctrl_q :
      hit(i_addr, rst_seq_pkg::REG_STATUS) ?
         {5'h00, outs_on_q, run_q, sampled} :
      hit(i_addr, rst_seq_pkg::REG_IDENT) ?
         {rst_seq_pkg::ID_CODE, rst_seq_pkg::REV_CODE} :
      hit(i_addr, rst_seq_pkg::REG_STRAPS) ? {5'h00, straps} :
      hit(i_addr, rst_seq_pkg::REG_CHAN_STAT) ? chan_stat_q : 8'h00;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ctrl_q <= rst_seq_pkg::CTRL_RESET_VAL;
         chan_stat_q <= rst_seq_pkg::CS_RESET_VAL;
         rdata_q <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_wdata;
         end
         if (wr_chan) begin
            chan_stat_q <= i_wdata;
         end
         rdata_q <= i_rd ? rd_mux : 8'h00;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Core sequence: low power, wait for loop settle, run.
   always_comb begin
      state_d = state_q;
      case (state_q)
         rst_seq_pkg::ST_LOWPWR: begin
            if (run_write) begin
               state_d = rst_seq_pkg::ST_SETTLE;
            end
         end
         rst_seq_pkg::ST_SETTLE: begin
            if (!ctrl_q[rst_seq_pkg::CTRL_RUN_BIT]) begin
               state_d = rst_seq_pkg::ST_LOWPWR;
            end else if (settled) begin
               state_d = rst_seq_pkg::ST_RUN;
            end
         end
         rst_seq_pkg::ST_RUN: begin
            if (!ctrl_q[rst_seq_pkg::CTRL_RUN_BIT]) begin
               state_d = rst_seq_pkg::ST_LOWPWR;
            end
         end
         default: begin
            state_d = rst_seq_pkg::ST_LOWPWR;
         end
      endcase
   end

   // The settle count restarts whenever the loop drops lock, so a glitchy
   // lock never lets the outputs open early.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_q <= rst_seq_pkg::ST_LOWPWR;
         settle_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_q != rst_seq_pkg::ST_SETTLE || !i_pll_locked) begin
            settle_q <= '0;
         end else if (!settled) begin
            settle_q <= settle_q + 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Straps: emphasis, original indicator and copy pins are inputs in reset.
   strap_latch u_straps (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_pins({i_copy_pin, i_original_indicator, i_emphasis_pin}),
      .o_sampled(sampled),
      .o_straps(straps)
   );

   block_start u_block (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_enable(outs_on_q),
      .i_master(blk_master),
      .i_subframe(i_subframe),
      .i_sync_in(i_block_start_sync),
      .o_sync_out(blk_sync_out),
      .o_block_first(blk_first)
   );

   //////////////////////////////////////////////////////////////////////////
   // Output stage. Data pin values are decoded here and only flopped below; enables
   // and mode pins are decoded in their flops, so each pin comes straight from a register.
   assign run_d = state_q != rst_seq_pkg::ST_LOWPWR;
   assign outs_on_d = state_q == rst_seq_pkg::ST_RUN;
   assign line_pos_d = outs_on_q && i_line_data;
   assign line_neg_d = outs_on_q && !i_line_data;
   assign audio_d = outs_on_q && i_audio_data;
   assign original_indicator_d = outs_on_q && is_original;
   assign emphasis_pin_d = outs_on_q && i_emphasis_value;
   assign copy_d = outs_on_q && !is_original;
   assign blk_d = blk_master && blk_sync_out;
   assign addr_bit_d = sw_q && straps[0];

   // Reset clears every flop except strap_oe_n_q and blk_oe_n_q, which it sets, on one edge, so devices sharing the reset line
   // leave it together and stay aligned.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         run_q <= 1'b0;
         outs_on_q <= 1'b0;
      end else begin
         run_q <= run_d;
         outs_on_q <= outs_on_d;
      end
   end

   // Line drivers are held low, not floated, so the cable sees a quiet idle.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         line_pos_q <= 1'b0;
         line_neg_q <= 1'b0;
         audio_q <= 1'b0;
      end else begin
         line_pos_q <= line_pos_d;
         line_neg_q <= line_neg_d;
         audio_q <= audio_d;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         original_indicator_q <= 1'b0;
         emphasis_pin_q <= 1'b0;
         copy_q <= 1'b0;
         strap_oe_n_q <= 1'b1;
      end else begin
         original_indicator_q <= original_indicator_d;
         emphasis_pin_q <= emphasis_pin_d;
         copy_q <= copy_d;
         strap_oe_n_q <= !sampled;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         blk_q <= 1'b0;
         blk_oe_n_q <= 1'b1;
         blk_first_q <= 1'b0;
      end else begin
         blk_q <= blk_d;
         blk_oe_n_q <= !blk_master;
         blk_first_q <= blk_first;
      end
   end

   // Mode pins are static by rule, yet they are still flopped so that every
   // output of the block comes from a register.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ipm_q <= 1'b0;
         sw_q <= 1'b0;
         addr_bit_q <= 1'b0;
      end else begin
         ipm_q <= i_input_port_master_select;
         sw_q <= !i_control_mode;
         addr_bit_q <= addr_bit_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_emphasis_pin = emphasis_pin_q;
   assign o_emphasis_pin_oe_n = strap_oe_n_q;
   assign o_original_indicator = original_indicator_q;
   assign o_original_indicator_oe_n = strap_oe_n_q;
   assign o_copy_pin = copy_q;
   assign o_copy_pin_oe_n = strap_oe_n_q;
   assign o_block_start_sync = blk_q;
   assign o_block_start_sync_oe_n = blk_oe_n_q;
   assign o_block_first = blk_first_q;
   assign o_line_out_pos = line_pos_q;
   assign o_line_out_neg = line_neg_q;
   assign o_audio_out = audio_q;
   assign o_core_active = run_q;
   assign o_input_port_master = ipm_q;
   assign o_software_mode = sw_q;
   assign o_addr_bit = addr_bit_q;
endmodule

/* File: rst_seq_props.sv */
// Concurrent checks on the reset and start-up sequencing ports.
`timescale 1ns/10ps
module rst_seq_props (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_control_mode,
   input wire logic i_input_port_master_select,
   input wire logic i_pll_locked,
   input wire logic i_emphasis_pin,
   input wire logic o_emphasis_pin_oe_n,
   input wire logic o_original_indicator_oe_n,
   input wire logic o_copy_pin_oe_n,
   input wire logic o_line_out_pos,
   input wire logic o_line_out_neg,
   input wire logic o_audio_out,
   input wire logic o_core_active,
   input wire logic o_input_port_master,
   input wire logic o_software_mode,
   input wire logic o_addr_bit
);
   // Slack of two cycles covers the settle state starting before core_active.
   localparam int SETTLE_MIN = rst_seq_pkg::PLL_SETTLE_CYC - 2;
   logic [11:0] lk_q;
   logic [11:0] lk_d;
   wire logic run_wr = i_wr && i_addr == rst_seq_pkg::REG_CONTROL && i_wdata[0];
   wire logic lk_hold = !o_core_active || !i_pll_locked;
   assign lk_d = lk_hold ? 12'h000 : lk_q + {11'h000, lk_q != 12'hFFF};
   always_ff @(posedge i_sys_clk) begin
      lk_q <= i_rst_n ? lk_d : 12'h000;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_pins_in;
      o_emphasis_pin_oe_n && o_copy_pin_oe_n && o_original_indicator_oe_n;
   endsequence
   sequence s_pins_out;
      !o_emphasis_pin_oe_n && !o_copy_pin_oe_n && !o_original_indicator_oe_n;
   endsequence
   property p_rst_quiet;
      $rose(i_rst_n) |-> !o_line_out_pos && !o_line_out_neg && !o_core_active
         && !o_audio_out && o_rdata == 8'h00;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not quiet after reset");
   property p_strap;
      $rose(i_rst_n) |-> s_pins_in ##2 s_pins_out;
   endproperty
   a_strap: assert property (p_strap)
      else $error("strap pins not turned back to outputs");
   property p_hold;
      $past(i_rst_n) && $past(i_rst_n, 2) && $past(i_rst_n, 3) |->
         $stable(o_addr_bit);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sampled strap changed outside reset");
   property p_addr;
      $rose(i_rst_n) && !i_control_mode |->
         ##3 o_addr_bit == $past(i_emphasis_pin, 3);
   endproperty
   a_addr: assert property (p_addr)
      else $error("address bit differs from emphasis strap");
   property p_run;
      run_wr && !o_core_active |-> ##2 o_core_active;
   endproperty
   a_run: assert property (p_run)
      else $error("run write did not start the core");
   property p_run_cause;
      $rose(o_core_active) |-> $past(run_wr, 2);
   endproperty
   a_run_cause: assert property (p_run_cause)
      else $error("core started without a run write");
   property p_settle;
      $rose(o_line_out_pos) |-> lk_q >= SETTLE_MIN;
   endproperty
   a_settle: assert property (p_settle)
      else $error("line output enabled before loop settled");
   property p_modes;
      $rose(i_rst_n) |-> ##3 o_input_port_master == i_input_port_master_select
         && o_software_mode == !i_control_mode;
   endproperty
   a_modes: assert property (p_modes)
      else $error("mode outputs differ from mode pins");
   property p_ident;
      i_rd && i_addr == rst_seq_pkg::REG_IDENT |=>
         o_rdata == {rst_seq_pkg::ID_CODE, rst_seq_pkg::REV_CODE};
   endproperty
   a_ident: assert property (p_ident)
      else $error("identity read wrong");
endmodule

/* File: far_side_model.sv */
// Far-side pins: strap pull resistors and an external block-start source.
`timescale 1ns/10ps
module far_side_model (
   input wire logic i_sys_clk,
   input wire logic [2:0] i_pull,
   input wire logic [2:0] i_drv,
   input wire logic [2:0] i_oe_n,
   input wire logic i_blk_go,
   input wire logic i_blk_drv,
   input wire logic i_blk_oe_n,
   output logic [2:0] o_pins,
   output logic o_blk
);
   logic [1:0] cnt_q = 2'h0;
   // A released strap pin settles to its resistor level, not the last drive.
   assign o_pins = (i_oe_n & i_pull) | (~i_oe_n & i_drv);
   // The source holds the pin for the least arming length; pulled low else.
   assign o_blk = i_blk_oe_n ? cnt_q != 2'h0 : i_blk_drv;
   always_ff @(posedge i_sys_clk) begin
      cnt_q <= i_blk_go ? 2'h3 : cnt_q - {1'b0, cnt_q != 2'h0};
   end
endmodule

/* File: reset_startup_mode_control_test.sv */
// Self-checking bench for reset, start-up and mode selection.
`timescale 1ns/10ps
module reset_startup_mode_control_test;
   logic i_sys_clk, i_rst_n, i_wr, i_rd, i_control_mode, i_pll_locked;
   logic i_input_port_master_select, i_subframe, i_line_data, i_audio_data;
   logic i_emphasis_value, blk_go;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rd_q;
   logic [2:0] pull;
   logic o_emphasis_pin, o_emphasis_pin_oe_n, o_original_indicator;
   logic o_original_indicator_oe_n, o_copy_pin, o_copy_pin_oe_n;
   logic o_block_start_sync, o_block_start_sync_oe_n, o_block_first;
   logic o_line_out_pos, o_line_out_neg, o_audio_out, o_core_active;
   logic o_input_port_master, o_software_mode, o_addr_bit;
   logic i_emphasis_pin, i_original_indicator, i_copy_pin, i_block_start_sync;
   int error_cnt, checks, n;
   reset_startup_mode_control u_dut (.*);
   far_side_model u_far (.i_sys_clk(i_sys_clk), .i_pull(pull),
      .i_drv({o_copy_pin, o_original_indicator, o_emphasis_pin}),
      .i_oe_n({o_copy_pin_oe_n, o_original_indicator_oe_n,
         o_emphasis_pin_oe_n}),
      .i_blk_go(blk_go), .i_blk_drv(o_block_start_sync),
      .i_blk_oe_n(o_block_start_sync_oe_n),
      .o_pins({i_copy_pin, i_original_indicator, i_emphasis_pin}),
      .o_blk(i_block_start_sync));
   //////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 rd_q = o_rdata;
   endtask
   task end_sim;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      error_cnt++;
      end_sim;
   end
   initial begin
      {i_rst_n, i_wr, i_rd, i_control_mode, i_pll_locked, i_subframe} = 6'h00;
      {i_line_data, i_audio_data, blk_go, i_addr, i_wdata} = 15'h0000;
      error_cnt = 0;
      checks = 0;
      void'($urandom(32'h24E9));
      pull = 3'($urandom);
      i_input_port_master_select = 1'($urandom);
      i_emphasis_value = 1'($urandom);
      tick(8);
      i_rst_n <= 1'b1;
      tick(4);
      chk({7'h00, o_addr_bit}, {7'h00, pull[0]});
      chk({5'h00, o_copy_pin_oe_n, o_original_indicator_oe_n,
         o_emphasis_pin_oe_n}, 8'h00);
      chk({o_input_port_master, o_software_mode},
         {i_input_port_master_select, 1'b1});
      rd(rst_seq_pkg::REG_STRAPS);
      chk(rd_q, {5'h00, pull});
      wr(rst_seq_pkg::REG_IDENT, 8'h00);
      rd(rst_seq_pkg::REG_IDENT);
      chk(rd_q, {rst_seq_pkg::ID_CODE, rst_seq_pkg::REV_CODE});
      rd(4'hF);
      chk(rd_q, 8'h00);
      $display("test straps and identity done");
      wr(rst_seq_pkg::REG_CONTROL, 8'h02);
      tick(3);
      chk({7'h00, o_core_active}, 8'h00);
      rd(rst_seq_pkg::REG_CONTROL);
      chk(rd_q, 8'h02);
      wr(rst_seq_pkg::REG_CONTROL, 8'h01);
      i_line_data <= 1'b1;
      i_audio_data <= 1'b1;
      tick(2);
      chk({7'h00, o_core_active}, 8'h01);
      chk({7'h00, o_block_start_sync_oe_n}, 8'h01);
      tick(100);
      chk({o_line_out_pos, o_audio_out}, 8'h00);
      i_pll_locked <= 1'b1;
      tick(1500);
      i_pll_locked <= 1'b0;
      tick(2);
      i_pll_locked <= 1'b1;
      chk({o_line_out_pos, o_audio_out}, 8'h00);
      n = 0;
      while (o_line_out_pos !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk(8'(n >= rst_seq_pkg::PLL_SETTLE_CYC
         && n <= rst_seq_pkg::PLL_SETTLE_CYC + 6), 8'h01);
      chk({o_line_out_pos, o_line_out_neg, o_audio_out, o_emphasis_pin},
         {4'h0, 3'h5, i_emphasis_value});
      $display("test run sequence done");
      for (int k = 0; k < 4; k++) begin
         wr(rst_seq_pkg::REG_CHAN_STAT, {k[1], 6'($urandom), k[0]});
         tick(3);
         chk({o_copy_pin, o_original_indicator},
            {!(k[1] ^ k[0]), k[1] ^ k[0]});
      end
      @(posedge i_sys_clk);
      blk_go <= 1'b1;
      @(posedge i_sys_clk);
      blk_go <= 1'b0;
      tick(4);
      i_subframe <= 1'b1;
      tick(1);
      i_subframe <= 1'b0;
      n = 0;
      while (o_block_first !== 1'b1 && n < 6) begin
         tick(1);
         n++;
      end
      chk(8'(n < 6), 8'h01);
      wr(rst_seq_pkg::REG_CONTROL, 8'h03);
      tick(3);
      chk({7'h00, o_block_start_sync_oe_n}, 8'h00);
      $display("test decode and block start done");
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      pull <= ~pull;
      tick(2);
      chk({o_line_out_pos, o_line_out_neg, o_core_active, o_audio_out,
         o_emphasis_pin_oe_n}, 8'h01);
      tick(6);
      i_rst_n <= 1'b1;
      tick(4);
      rd(rst_seq_pkg::REG_CONTROL);
      chk(rd_q, 8'h00);
      tick(20);
      chk({7'h00, o_addr_bit}, {7'h00, pull[0]});
      $display("test second reset done");
      end_sim;
   end
endmodule
bind reset_startup_mode_control rst_seq_props u_props (.*);
